// >>> acq_map.vh
// Register map, field positions, reset values and timing counts of the acquisition sequencer
`ifndef ACQ_MAP_VH
`define ACQ_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL        8'h00
`define OFS_EXTERNAL_TRIGGER_PIN_CFG    8'h04
`define OFS_QUEUE_LEN   8'h08
`define OFS_RATE_DIV    8'h0C
`define OFS_STATUS      8'h10
`define OFS_SW_RESULT   8'h14
`define OFS_QUEUE_BASE  8'h20
`define OFS_QUEUE_LAST  8'h3C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_START      0
`define CTRL_STOP       1
`define CTRL_SWCONV     2
`define CTRL_EXTERNAL_TRIGGER_PIN_EN    3
`define CTRL_EXT_CLK    4
`define CTRL_RETRIG     5
`define CTRL_SWCH_LO    8
`define CTRL_SWRG_LO    12
`define EXTERNAL_TRIGGER_PIN_LEVEL      0
`define EXTERNAL_TRIGGER_PIN_INVERT     1
`define ST_RUNNING      0
`define ST_ARMED        1
`define ST_BUSY         2
`define ST_SW_DONE      3
`define ST_OVERRUN      4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_EXTERNAL_TRIGGER_PIN_CFG    2'h0
`define RST_QUEUE_LEN   3'h0
`define RST_RATE_DIV    32'h0000_0019

// ----------------------------------------------------------------
// Timing and sizes
// ----------------------------------------------------------------
`define CLK_PERIOD_NS   40
`define SAMPLE_MIN_NS   1000
`define MIN_DIV         ((`SAMPLE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BLINK_MS        50
`define BLINK_CYC       ((`BLINK_MS * 1000000) / `CLK_PERIOD_NS)
`define BLOCK_WORDS     32
`define QUEUE_DEPTH     8
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// >>> queue_mem.v
// Channel and range queue storage with registered read data
`timescale 1ns/1ps
`include "acq_map.vh"

module queue_mem (
	input  wire       clk_i,
	input  wire       rst_i,
	input  wire       wr_en_i,
	input  wire [2:0] wr_addr_i,
	input  wire [5:0] wr_data_i,
	input  wire [2:0] rd_addr_i,
	output reg  [5:0] rd_data_o
);

	reg [5:0] mem [0:`QUEUE_DEPTH-1];

	always @(posedge clk_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
	end

	// Reset only clears the output; entries hold whatever software loaded
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_data_o <= 6'h00;
		end else begin
			rd_data_o <= mem[rd_addr_i];
		end
	end

endmodule

// >>> analog_acquisition_sequencer.v
// Analog acquisition sequencer with AXI4-Lite registers, pacing, trigger and output buffer
// Behaviour
// - One conversion per software convert command
// - Scan queue of one to eight channels
// - Scan results go to FIFO until stop
// - Output drained in blocks, host keeps draining
// - Aggregate rate capped at one MS/s with the internal clock; external clock edges are not capped
// - Scan starts on command or trigger
// - Trigger edge or level, selectable polarity
// - Reset trigger setting: rising edge
// - Retrigger re-arms after each activation
// - External sample clock alternative to internal
// - Clock output mirrors internal sample clock
// - External mode: pulse per external rising edge
// - Activity output blinks during transfers only
// - Queue entry holds channel and range
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "acq_map.vh"

module analog_acquisition_sequencer #(
	parameter [20:0] BLINK_CYC = `BLINK_CYC
) (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg         conv_start_o,
	output reg  [2:0]  conv_channel_o,
	output reg  [2:0]  conv_range_o,
	input  wire        conv_done_i,
	input  wire [12:0] conv_data_i,
	output reg         fifo_valid_o,
	output reg  [15:0] fifo_data_o,
	input  wire        fifo_ready_i,
	output reg         block_done_o,
	input  wire        ext_sample_clock_in_i,
	input  wire        external_trigger_pin_i,
	output reg         sample_clock_out_o,
	output reg         activity_o
);

	localparam [4:0] S_IDLE = 5'h01;
	localparam [4:0] S_ARM  = 5'h02;
	localparam [4:0] S_RUN  = 5'h04;
	localparam [4:0] S_CONV = 5'h08;
	localparam [4:0] S_SW   = 5'h10;
	localparam [31:0] MIN_DIV = `MIN_DIV;

	function [31:0] merge;
		input [31:0] old;
		input [31:0] wd;
		input [3:0]  be;
		integer k;
		begin
			merge = old;
			for (k = 0; k < 4; k = k + 1) begin
				if (be[k]) begin
					merge[k*8 +: 8] = wd[k*8 +: 8];
				end
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	reg        awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	reg        aw_got_ff, w_got_ff;
	reg [7:0]  awaddr_ff;
	reg [31:0] wdata_ff;
	reg [3:0]  wstrb_ff;
	reg [1:0]  bresp_ff, rresp_ff;
	reg [31:0] rdata_ff;
	wire       wr_en = aw_got_ff & w_got_ff & ~bvalid_ff;
	wire       wr_q  = wr_en & (awaddr_ff >= `OFS_QUEUE_BASE) & (awaddr_ff <= `OFS_QUEUE_LAST);
	wire       wr_ok = wr_q | (awaddr_ff <= `OFS_STATUS);
	wire [31:0] wr_word;

	assign s_axi_awready = awready_ff;
	assign s_axi_wready  = wready_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;
	assign wr_word = merge(32'h0000_0000, wdata_ff, wstrb_ff);

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			awready_ff <= 1'b1;
			wready_ff  <= 1'b1;
			bvalid_ff  <= 1'b0;
			aw_got_ff  <= 1'b0;
			w_got_ff   <= 1'b0;
			awaddr_ff  <= 8'h00;
			wdata_ff   <= 32'h0000_0000;
			wstrb_ff   <= 4'h0;
			bresp_ff   <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && awready_ff) begin
				aw_got_ff  <= 1'b1;
				awaddr_ff  <= s_axi_awaddr;
				awready_ff <= 1'b0;
			end
			if (s_axi_wvalid && wready_ff) begin
				w_got_ff  <= 1'b1;
				wdata_ff  <= s_axi_wdata;
				wstrb_ff  <= s_axi_wstrb;
				wready_ff <= 1'b0;
			end
			if (wr_en) begin
				aw_got_ff <= 1'b0;
				w_got_ff  <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (bvalid_ff && s_axi_bready) begin
				bvalid_ff  <= 1'b0;
				awready_ff <= 1'b1;
				wready_ff  <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Control and status registers
	// ----------------------------------------------------------------
	reg        external_trigger_pin_en_ff, ext_clk_ff, retrig_ff;
	reg [2:0]  sw_chan_ff, sw_range_ff;
	reg [1:0]  external_trigger_pin_cfg_ff;
	reg [2:0]  qlen_ff;
	reg [31:0] rate_div_ff;
	reg        sw_done_ff, overrun_ff;
	reg [12:0] sw_result_ff;
	reg [4:0]  state_ff;
	wire       cmd_start  = wr_en && awaddr_ff == `OFS_CTRL && wr_word[`CTRL_START];
	wire       cmd_stop   = wr_en && awaddr_ff == `OFS_CTRL && wr_word[`CTRL_STOP];
	wire       cmd_swconv = wr_en && awaddr_ff == `OFS_CTRL && wr_word[`CTRL_SWCONV];
	wire       clr_status = wr_en && awaddr_ff == `OFS_STATUS;
	wire       set_sw_done;
	wire       set_overrun;
	wire [31:0] status_word = {27'h000_0000, overrun_ff, sw_done_ff,
		(state_ff == S_CONV) | (state_ff == S_SW), state_ff == S_ARM,
		(state_ff == S_RUN) | (state_ff == S_CONV)};

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			external_trigger_pin_en_ff  <= 1'b0;
			ext_clk_ff  <= 1'b0;
			retrig_ff   <= 1'b0;
			sw_chan_ff  <= 3'h0;
			sw_range_ff <= 3'h0;
			external_trigger_pin_cfg_ff <= `RST_EXTERNAL_TRIGGER_PIN_CFG;
			qlen_ff     <= `RST_QUEUE_LEN;
			rate_div_ff <= `RST_RATE_DIV;
			sw_done_ff  <= 1'b0;
			overrun_ff  <= 1'b0;
		end else begin
			if (wr_en && awaddr_ff == `OFS_CTRL) begin
				external_trigger_pin_en_ff  <= wr_word[`CTRL_EXTERNAL_TRIGGER_PIN_EN];
				ext_clk_ff  <= wr_word[`CTRL_EXT_CLK];
				retrig_ff   <= wr_word[`CTRL_RETRIG];
				sw_chan_ff  <= wr_word[`CTRL_SWCH_LO +: 3];
				sw_range_ff <= wr_word[`CTRL_SWRG_LO +: 3];
			end
			if (wr_en && awaddr_ff == `OFS_EXTERNAL_TRIGGER_PIN_CFG) begin
				external_trigger_pin_cfg_ff <= wr_word[1:0];
			end
			if (wr_en && awaddr_ff == `OFS_QUEUE_LEN) begin
				qlen_ff <= wr_word[2:0];
			end
			if (wr_en && awaddr_ff == `OFS_RATE_DIV) begin
				rate_div_ff <= wr_word;
			end
			// Set beats a same-cycle clear so no event is lost
			if (set_sw_done) begin
				sw_done_ff <= 1'b1;
			end else if (clr_status && wr_word[`ST_SW_DONE]) begin
				sw_done_ff <= 1'b0;
			end
			if (set_overrun) begin
				overrun_ff <= 1'b1;
			end else if (clr_status && wr_word[`ST_OVERRUN]) begin
				overrun_ff <= 1'b0;
			end
		end
	end

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			arready_ff <= 1'b1;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h0000_0000;
			rresp_ff   <= `RESP_OKAY;
		end else if (s_axi_arvalid && arready_ff) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b1;
			rresp_ff   <= `RESP_OKAY;
			case (s_axi_araddr)
				`OFS_CTRL: begin
					rdata_ff <= {17'h0_0000, sw_range_ff, 1'b0, sw_chan_ff, 2'h0,
						retrig_ff, ext_clk_ff, external_trigger_pin_en_ff, 3'h0};
				end
				`OFS_EXTERNAL_TRIGGER_PIN_CFG:  rdata_ff <= {30'h0000_0000, external_trigger_pin_cfg_ff};
				`OFS_QUEUE_LEN: rdata_ff <= {29'h0000_0000, qlen_ff};
				`OFS_RATE_DIV:  rdata_ff <= rate_div_ff;
				`OFS_STATUS:    rdata_ff <= status_word;
				`OFS_SW_RESULT: rdata_ff <= {19'h0_0000, sw_result_ff};
				default: begin
					// Queue entries are write-only and read as zero
					rdata_ff <= 32'h0000_0000;
					if (s_axi_araddr < `OFS_QUEUE_BASE || s_axi_araddr > `OFS_QUEUE_LAST) begin
						rresp_ff <= `RESP_SLVERR;
					end
				end
			endcase
		end else if (rvalid_ff && s_axi_rready) begin
			rvalid_ff  <= 1'b0;
			arready_ff <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Pin synchronisers, sample pacing and trigger detection
	// ----------------------------------------------------------------
	reg [2:0]  eck_sync_ff, trg_sync_ff;
	reg [31:0] div_cnt_ff;
	wire [31:0] div_eff = (rate_div_ff < MIN_DIV) ? MIN_DIV : rate_div_ff;
	wire       int_tick = div_cnt_ff >= div_eff - 32'h0000_0001;
	wire       ext_rise = eck_sync_ff[1] & ~eck_sync_ff[2];
	wire       tick     = ext_clk_ff ? ext_rise : int_tick;
	wire       trg_rise = trg_sync_ff[1] & ~trg_sync_ff[2];
	wire       trg_fall = ~trg_sync_ff[1] & trg_sync_ff[2];
	wire       trg_lvl  = trg_sync_ff[1] ^ external_trigger_pin_cfg_ff[`EXTERNAL_TRIGGER_PIN_INVERT];
	wire       trg_edge = external_trigger_pin_cfg_ff[`EXTERNAL_TRIGGER_PIN_INVERT] ? trg_fall : trg_rise;
	wire       trg_evt  = external_trigger_pin_cfg_ff[`EXTERNAL_TRIGGER_PIN_LEVEL] ? trg_lvl : trg_edge;

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			eck_sync_ff        <= 3'h0;
			trg_sync_ff        <= 3'h0;
			div_cnt_ff         <= 32'h0000_0000;
			sample_clock_out_o <= 1'b0;
		end else begin
			eck_sync_ff <= {eck_sync_ff[1:0], ext_sample_clock_in_i};
			trg_sync_ff <= {trg_sync_ff[1:0], external_trigger_pin_i};
			div_cnt_ff  <= int_tick ? 32'h0000_0000 : div_cnt_ff + 32'h0000_0001;
			if (ext_clk_ff) begin
				sample_clock_out_o <= ext_rise;
			end else begin
				sample_clock_out_o <= div_cnt_ff < {1'b0, div_eff[31:1]};
			end
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	reg  [2:0] idx_ff;
	reg        push_ff;
	reg [15:0] push_data_ff;
	wire [5:0] q_entry;
	reg        v1_ff;
	wire       room    = ~v1_ff;
	wire       last    = idx_ff == qlen_ff;
	wire       conv_ok = (state_ff == S_CONV) & conv_done_i;
	assign set_sw_done = (state_ff == S_SW) & conv_done_i;
	assign set_overrun = tick & (((state_ff == S_RUN) & ~room) | (state_ff == S_CONV));

	queue_mem u_queue (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.wr_en_i   (wr_q),
		.wr_addr_i (awaddr_ff[4:2]),
		.wr_data_i ({wr_word[6:4], wr_word[2:0]}),
		.rd_addr_i (idx_ff),
		.rd_data_o (q_entry)
	);

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_ff       <= S_IDLE;
			idx_ff         <= 3'h0;
			conv_start_o   <= 1'b0;
			conv_channel_o <= 3'h0;
			conv_range_o   <= 3'h0;
			sw_result_ff   <= 13'h0000;
			push_ff        <= 1'b0;
			push_data_ff   <= 16'h0000;
		end else begin
			conv_start_o <= 1'b0;
			push_ff      <= 1'b0;
			case (state_ff)
				S_IDLE: begin
					idx_ff <= 3'h0;
					// Fields of the commanding write itself; stored copies land only now
					if (cmd_start) begin
						state_ff <= wr_word[`CTRL_EXTERNAL_TRIGGER_PIN_EN] ? S_ARM : S_RUN;
					end else if (cmd_swconv) begin
						state_ff       <= S_SW;
						conv_start_o   <= 1'b1;
						conv_channel_o <= wr_word[`CTRL_SWCH_LO +: 3];
						conv_range_o   <= wr_word[`CTRL_SWRG_LO +: 3];
					end
				end
				S_ARM: begin
					if (cmd_stop) begin
						state_ff <= S_IDLE;
					end else if (trg_evt) begin
						state_ff <= S_RUN;
					end
				end
				S_RUN: begin
					if (cmd_stop) begin
						state_ff <= S_IDLE;
					end else if (tick && room) begin
						state_ff       <= S_CONV;
						conv_start_o   <= 1'b1;
						conv_channel_o <= q_entry[2:0];
						conv_range_o   <= q_entry[5:3];
					end
				end
				S_CONV: begin
					if (cmd_stop) begin
						state_ff <= S_IDLE;
					end else if (conv_ok) begin
						push_ff      <= 1'b1;
						push_data_ff <= {conv_channel_o, conv_data_i};
						idx_ff       <= last ? 3'h0 : idx_ff + 3'h1;
						state_ff     <= (last && external_trigger_pin_en_ff && retrig_ff) ? S_ARM : S_RUN;
					end
				end
				S_SW: begin
					if (conv_done_i) begin
						sw_result_ff <= conv_data_i;
						state_ff     <= S_IDLE;
					end
				end
				default: state_ff <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Two-entry output buffer, block marking and activity blink
	// ----------------------------------------------------------------
	// A conversion only starts with the second slot free, but a push landing in that same cycle can fill it, so its word can then overwrite d1_ff
	reg [15:0] d1_ff;
	reg [4:0]  blk_cnt_ff;
	reg [20:0] act_cnt_ff;
	wire       pop = fifo_valid_o & fifo_ready_i;

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			fifo_valid_o <= 1'b0;
			fifo_data_o  <= 16'h0000;
			v1_ff        <= 1'b0;
			d1_ff        <= 16'h0000;
			blk_cnt_ff   <= 5'h00;
			block_done_o <= 1'b0;
			act_cnt_ff   <= 21'h00_0000;
			activity_o   <= 1'b0;
		end else begin
			if (push_ff && !pop) begin
				if (!fifo_valid_o) begin
					fifo_valid_o <= 1'b1;
					fifo_data_o  <= push_data_ff;
				end else begin
					v1_ff <= 1'b1;
					d1_ff <= push_data_ff;
				end
			end else if (pop && !push_ff) begin
				fifo_valid_o <= v1_ff;
				fifo_data_o  <= d1_ff;
				v1_ff        <= 1'b0;
			end else if (pop && push_ff) begin
				fifo_data_o <= v1_ff ? d1_ff : push_data_ff;
				d1_ff       <= push_data_ff;
			end
			block_done_o <= 1'b0;
			if (pop) begin
				blk_cnt_ff <= blk_cnt_ff + 5'h01;
				if (blk_cnt_ff == `BLOCK_WORDS - 1) begin
					block_done_o <= 1'b1;
				end
			end
			// Traffic starts a full on/off blink period only once the previous period has run out
			if (pop && act_cnt_ff == 21'h00_0000) begin
				act_cnt_ff <= BLINK_CYC;
			end else if (act_cnt_ff != 21'h00_0000) begin
				act_cnt_ff <= act_cnt_ff - 21'h00_0001;
			end
			activity_o <= act_cnt_ff > {1'b0, BLINK_CYC[20:1]};
		end
	end

endmodule

// >>> acq_seq_assertions.sv
// Port checker for the acquisition sequencer, bound to its top module
`timescale 1ns/1ps
module acq_seq_checker (
	input wire        clk_i,
	input wire        rst_i,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire        s_axi_bvalid,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire        s_axi_rvalid,
	input wire        conv_start_o,
	input wire [2:0]  conv_channel_o,
	input wire [2:0]  conv_range_o,
	input wire        conv_done_i,
	input wire        fifo_valid_o,
	input wire [15:0] fifo_data_o,
	input wire        fifo_ready_i,
	input wire        block_done_o,
	input wire        activity_o
);
	// ----
	// Properties
	// ----
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	conv_pulse_a: assert property (conv_start_o |=> !conv_start_o)
		else $error("convert start longer than one cycle");
	entry_hold_a: assert property (!conv_start_o |-> $stable({conv_channel_o, conv_range_o}))
		else $error("channel or range moved between starts");
	fifo_hold_a: assert property (fifo_valid_o && !fifo_ready_i |=> fifo_valid_o && $stable(fifo_data_o))
		else $error("buffer word dropped or changed while stalled");
	fifo_lat_a: assert property ($rose(fifo_valid_o) |-> $past(conv_done_i, 2))
		else $error("scan word not two edges after done");
	block_pulse_a: assert property (block_done_o |-> $past(fifo_valid_o && fifo_ready_i) && !$past(block_done_o))
		else $error("block pulse without word leaving");
	blink_start_a: assert property ($rose(activity_o) |-> $past(fifo_valid_o && fifo_ready_i, 2))
		else $error("activity lit without a transfer");
	wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> ##1 s_axi_bvalid)
		else $error("write response late");
	rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	cover property (fifo_valid_o && !fifo_ready_i);
	cover property (block_done_o);
	cover property (conv_start_o ##1 activity_o);
endmodule
bind analog_acquisition_sequencer acq_seq_checker i_chk (.clk_i, .rst_i, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .conv_start_o, .conv_channel_o, .conv_range_o, .conv_done_i, .fifo_valid_o,
	.fifo_data_o, .fifo_ready_i, .block_done_o, .activity_o);

// >>> conv_fifo_model.sv
// Converter and output FIFO model facing the sequencer
`timescale 1ns/1ps
module conv_fifo_model (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        conv_start_i,
	input  wire [2:0]  conv_channel_i,
	input  wire [2:0]  conv_range_i,
	input  wire        slow_i,
	input  wire        stall_i,
	output reg         conv_done_o,
	output reg  [12:0] conv_data_o,
	output reg         fifo_ready_o
);
	reg [3:0] wait_ff;
	reg [5:0] sel_ff;
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wait_ff <= 4'h0;
			sel_ff <= 6'h00;
			conv_done_o <= 1'b0;
			conv_data_o <= 13'h0000;
			fifo_ready_o <= 1'b0;
		end else begin
			conv_done_o <= 1'b0;
			fifo_ready_o <= !stall_i;
			// Result lines toggle outside a done pulse so stale data never looks valid
			conv_data_o <= ~conv_data_o;
			if (conv_start_i) begin
				wait_ff <= slow_i ? 4'h9 : 4'h2;
				sel_ff <= {conv_channel_i, conv_range_i};
			end else if (wait_ff != 4'h0) begin
				wait_ff <= wait_ff - 4'h1;
				if (wait_ff == 4'h1) begin
					conv_done_o <= 1'b1;
					conv_data_o <= {sel_ff, 7'h55};
				end
			end
		end
	end
endmodule

// >>> tb.sv
// Self-checking bench for the acquisition sequencer
`timescale 1ns/1ps
`include "acq_map.vh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
	reg         clk_i = 1'b0;
	reg         rst_i = 1'b1;
	reg  [7:0]  s_axi_awaddr = 8'h00;
	reg         s_axi_awvalid = 1'b0;
	reg  [31:0] s_axi_wdata = 32'h0000_0000;
	reg  [3:0]  s_axi_wstrb = 4'hf;
	reg         s_axi_wvalid = 1'b0;
	reg         s_axi_bready = 1'b0;
	reg  [7:0]  s_axi_araddr = 8'h00;
	reg         s_axi_arvalid = 1'b0;
	reg         s_axi_rready = 1'b0;
	reg         ext_sample_clock_in_i = 1'b0;
	reg         external_trigger_pin_i = 1'b0;
	reg         slow = 1'b0;
	reg         stall = 1'b0;
	wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0]  s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire        conv_start_o, conv_done_i, fifo_valid_o, fifo_ready_i, block_done_o;
	wire [2:0]  conv_channel_o, conv_range_o;
	wire [12:0] conv_data_i;
	wire [15:0] fifo_data_o;
	wire        sample_clock_out_o, activity_o;
	integer     fail_count = 0, checks_done = 0, cyc = 0, scnt = 0, sccnt = 0, wcnt = 0, bcnt = 0;
	integer     tl = 0, tp = 0, sl = 0, sp = 0, i, j, k;
	reg         sco_q = 1'b0, act_seen = 1'b0;
	reg  [15:0] words[$];
	reg  [31:0] rd;
	reg  [5:0]  e;
	analog_acquisition_sequencer #(.BLINK_CYC(21'd16)) i_analog_acquisition_sequencer (.clk_i,
		.rst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.conv_start_o, .conv_channel_o, .conv_range_o, .conv_done_i, .conv_data_i, .fifo_valid_o,
		.fifo_data_o, .fifo_ready_i, .block_done_o, .ext_sample_clock_in_i,
		.external_trigger_pin_i, .sample_clock_out_o, .activity_o);
	conv_fifo_model i_conv_fifo_model (.clk_i, .rst_i, .conv_start_i(conv_start_o),
		.conv_channel_i(conv_channel_o), .conv_range_i(conv_range_o), .slow_i(slow),
		.stall_i(stall), .conv_done_o(conv_done_i), .conv_data_o(conv_data_i),
		.fifo_ready_o(fifo_ready_i));
	always #20 clk_i = ~clk_i;
	// ----
	// Monitor and bus tasks
	// ----
	always @(posedge clk_i) begin
		cyc++;
		if (fifo_valid_o && fifo_ready_i) begin
			words.push_back(fifo_data_o);
			wcnt++;
		end
		if (block_done_o) bcnt++;
		if (conv_start_o) begin
			scnt++;
			tp = tl;
			tl = cyc;
		end
		if (sample_clock_out_o && !sco_q) begin
			sccnt++;
			sp = sl;
			sl = cyc;
		end
		sco_q = sample_clock_out_o;
		if (activity_o) act_seen = 1'b1;
	end
	task wt(input integer n);
		repeat (n) @(posedge clk_i);
	endtask
	task axw(input [7:0] a, input [31:0] d, input [1:0] er);
		@(posedge clk_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge clk_i);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		`CHK(s_axi_bresp, er)
	endtask
	task axr(input [7:0] a, input [1:0] er, output [31:0] d);
		@(posedge clk_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge clk_i);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		`CHK(s_axi_rresp, er)
	endtask
	function [5:0] qent(input integer n);
		qent = {3'd7 - {n[1:0], 1'b0}, 3'd1 + n[2:0]};
	endfunction
	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#1600000;
		fail_count++;
		tally_and_finish;
	end
	initial begin
		wt(8);
		rst_i <= 1'b0;
		wt(1);
		`CHK(activity_o, 1'b0)
		axr(`OFS_EXTERNAL_TRIGGER_PIN_CFG, `RESP_OKAY, rd); `CHK(rd[1:0], `RST_EXTERNAL_TRIGGER_PIN_CFG)
		axr(`OFS_RATE_DIV, `RESP_OKAY, rd); `CHK(rd, `RST_RATE_DIV)
		axr(8'h18, `RESP_SLVERR, rd); `CHK(rd, 32'h0000_0000)
		k = scnt;
		axw(`OFS_CTRL, 32'h0000_3504, `RESP_OKAY);
		wt(30);
		`CHK(scnt - k, 1)
		axr(`OFS_SW_RESULT, `RESP_OKAY, rd); `CHK(rd[12:0], {3'd5, 3'd3, 7'h55})
		axr(`OFS_STATUS, `RESP_OKAY, rd); `CHK(rd[3], 1'b1)
		for (i = 0; i < 3; i++) begin
			e = qent(i);
			axw(`OFS_QUEUE_BASE + 8'h04 * i[7:0], {e[2:0], 1'b0, e[5:3]}, `RESP_OKAY);
		end
		axw(`OFS_QUEUE_LEN, 32'h0000_0002, `RESP_OKAY);
		// Divider below the floor must still pace at the floor rate
		axw(`OFS_RATE_DIV, 32'h0000_0004, `RESP_OKAY);
		words.delete();
		axw(`OFS_CTRL, 32'h0000_0001, `RESP_OKAY);
		wt(200);
		`CHK(tl - tp, 25)
		`CHK(sl - sp, 25)
		stall <= 1'b1;
		wt(150);
		axr(`OFS_STATUS, `RESP_OKAY, rd); `CHK(rd[4:0] & 5'h11, 5'h11)
		stall <= 1'b0;
		axw(`OFS_STATUS, 32'h0000_0010, `RESP_OKAY);
		wt(900);
		axw(`OFS_CTRL, 32'h0000_0002, `RESP_OKAY);
		wt(60);
		k = scnt;
		wt(100);
		`CHK(scnt - k, 0)
		`CHK(wcnt >= 32, 1'b1)
		for (i = 0; i < words.size(); i++) begin
			e = qent(i % 3);
			`CHK(words[i], {e[5:3], e, 7'h55})
		end
		slow <= 1'b1;
		for (i = 0; i < 4; i++) begin
			external_trigger_pin_i <= i[1];
			axw(`OFS_EXTERNAL_TRIGGER_PIN_CFG, i, `RESP_OKAY);
			k = scnt;
			axw(`OFS_CTRL, 32'h0000_0009, `RESP_OKAY);
			wt(60);
			axr(`OFS_STATUS, `RESP_OKAY, rd); `CHK(rd[1:0], 2'b10)
			`CHK(scnt - k, 0)
			external_trigger_pin_i <= ~i[1];
			wt(60);
			axr(`OFS_STATUS, `RESP_OKAY, rd); `CHK(rd[0], 1'b1)
			`CHK(scnt > k, 1'b1)
			axw(`OFS_CTRL, 32'h0000_0002, `RESP_OKAY);
			wt(20);
		end
		external_trigger_pin_i <= 1'b0;
		axw(`OFS_EXTERNAL_TRIGGER_PIN_CFG, 32'h0000_0000, `RESP_OKAY);
		axw(`OFS_QUEUE_LEN, 32'h0000_0000, `RESP_OKAY);
		axw(`OFS_CTRL, 32'h0000_0029, `RESP_OKAY);
		for (i = 0; i < 2; i++) begin
			wt(20);
			k = scnt;
			external_trigger_pin_i <= 1'b1;
			wt(60);
			external_trigger_pin_i <= 1'b0;
			wt(20);
			`CHK(scnt - k, 1)
			axr(`OFS_STATUS, `RESP_OKAY, rd); `CHK(rd[1], 1'b1)
		end
		axw(`OFS_CTRL, 32'h0000_0002, `RESP_OKAY);
		slow <= 1'b0;
		axw(`OFS_CTRL, 32'h0000_0011, `RESP_OKAY);
		// Let a last internal clock edge be counted before the baseline is taken
		wt(2);
		k = scnt;
		j = sccnt;
		repeat (3) begin
			wt(10);
			ext_sample_clock_in_i <= 1'b1;
			wt(10);
			ext_sample_clock_in_i <= 1'b0;
		end
		wt(20);
		`CHK(scnt - k, 3)
		`CHK(sccnt - j, 3)
		axw(`OFS_CTRL, 32'h0000_0002, `RESP_OKAY);
		wt(40);
		`CHK(bcnt, wcnt / 32)
		`CHK(act_seen, 1'b1)
		tally_and_finish;
	end
endmodule
